/* rtl/mdg_defs.svh */
// Purpose: addresses, field layouts, reset values of the register slice
// Assumes: 7-bit register address, 16-bit register words
// Notes: definitions only
`ifndef MDG_DEFS_SVH
`define MDG_DEFS_SVH

// register addresses
`define MDG_ADDR_IDEAL_A 7'h21
`define MDG_ADDR_IDEAL_B 7'h22
`define MDG_ADDR_RES_FIRST 7'h23
`define MDG_ADDR_RES_LAST 7'h32
`define MDG_ADDR_CODE_FIRST 7'h33
`define MDG_ADDR_CODE_LAST 7'h3E
`define MDG_ADDR_CLR_FIRST 7'h3F
`define MDG_ADDR_CLR_LAST 7'h4A
`define MDG_ADDR_PIN 7'h4B
`define MDG_ADDR_CFG 7'h4C

// reset values
`define MDG_IDEAL_RST 8'h00
`define MDG_CODE_RST 12'h000
`define MDG_RES_RST 12'h000
`define MDG_PIN_RST 8'hFF
`define MDG_CFG_RST 16'h2000

// field layouts
`define MDG_IDEAL_FILL 8'hFF
`define MDG_ZERO_BYTE 8'h00
`define MDG_ZERO_NIBBLE 4'h0
`define MDG_CFG_WMASK 16'h3EFF
`define MDG_PIN_SENSOR_ONE 8'h30
`define MDG_PIN_SENSOR_TWO 8'hC0
`define MDG_CODE_MSB 11

`endif

/* rtl/mdg_pkg.sv */
// Purpose: shared types of the register slice
// Assumes: constants live in mdg_defs.svh
// Notes: nothing here is imported; use mdg_pkg::name
package mdg_pkg;

  // register word and converter code
  typedef logic [15:0] mdg_word_t;
  typedef logic [11:0] mdg_code_t;

  // which serial port is selected, shapes ideality layout
  typedef enum logic {MDG_PORT_SPI, MDG_PORT_I2C} mdg_port_t;

endpackage

/* rtl/mdg_pin_port.sv */
// Purpose: eight open-drain general-purpose pins and their register
// Assumes: pin levels arrive synchronous to clock_i
// Notes: pins are only ever driven low; a pull-up makes the high
`timescale 1ns/1ps
`include "mdg_defs.svh"
module mdg_pin_port #(
  parameter int NUM_PINS = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register write
  input wire logic wr_i,
  input wire logic [NUM_PINS-1:0] wdata_i,
  // pins lent to the remote sensors
  input wire logic [NUM_PINS-1:0] ignore_i,
  // pin levels and drive
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  // level seen by a register read
  output logic [NUM_PINS-1:0] level_o
);

  logic [NUM_PINS-1:0] latch_reg;

  // reset pattern cut to the pin count on purpose
  localparam logic [NUM_PINS-1:0] PIN_RST_BITS = NUM_PINS'(`MDG_PIN_RST);

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_pin
      // written bit: one releases, zero pulls low
      always_ff @(posedge clock_i)
      begin
        if (rst_i)
          latch_reg[g] <= PIN_RST_BITS[g]; // see [R12]
        else if (wr_i && !ignore_i[g]) // see [R13] [R14]
          latch_reg[g] <= wdata_i[g]; // see [R10]
      end

      // drive only while released-bit is zero and pin not lent
      always_ff @(posedge clock_i)
      begin
        if (rst_i)
        begin
          pin_oe_o[g] <= 1'b0;
          pin_o[g] <= 1'b0;
        end
        else
        begin
          pin_oe_o[g] <= !latch_reg[g] && !ignore_i[g]; // see [R10]
          pin_o[g] <= 1'b0;
        end
      end

      // lent pins read zero so sensor activity never shows
      always_comb
        level_o[g] = pin_i[g] && !ignore_i[g]; // see [R11] [R13] [R14]
    end
  endgenerate

endmodule

/* rtl/mdg_regs.sv */
// Purpose: data and pin register slice of a monitor and control device
// Assumes: serial port already turned frames into word strobes
// Notes: reads answer one cycle after the strobe from rd_data_o
`timescale 1ns/1ps
`include "mdg_defs.svh"

// Summary of operation
// [R1] two ideality registers; only the adjust byte matters, rest ignored
// [R2] serial-peripheral mode: adjust in bits 7:0, top byte zero, reset 0000h
// [R3] two-wire mode: adjust in top byte, low byte reads FFh, reset 00FFh
// [R4] adjust is signed 80h..7Fh; zero means default ideality 1.008
// [R5] sixteen read-only 12-bit result registers, top nibble reads zero
// [R6] single-ended channel n result goes to register n, straight binary
// [R7] differential pairs 0/1 and 2/3 store twos complement in 0 and 2
// [R8] twelve output code registers feed converter latches, reset zero
// [R9] twelve clear codes load into latch when converter cleared, reset zero
// [R10] pin bit one releases pin, zero drives it low
// [R11] pin read returns sampled pin levels, bits 15:8 zero
// [R12] any reset sets all pin bits to one, pins released
// [R13] sensor one enabled: pin bits 4 and 5 ignored
// [R14] sensor two enabled: pin bits 6 and 7 ignored
// [R15] main configuration register at 4Ch resets to 2000h
// [R16] sensor enable bits high mean active, low mean disabled
// [R17] host writes to result registers are discarded
module mdg_regs #(
  parameter int NUM_RES = 16,
  parameter int NUM_OUT = 12,
  parameter int NUM_PINS = 8
) (
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  // port selection
  input wire mdg_pkg::mdg_port_t port_sel_i,
  // register access from the serial port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire mdg_pkg::mdg_word_t reg_wdata_i,
  output mdg_pkg::mdg_word_t rd_data_o,
  output logic rd_valid_o,
  // converter results
  input wire logic conv_wr_i,
  input wire logic conv_diff_i,
  input wire logic [3:0] conv_ch_i,
  input wire mdg_pkg::mdg_code_t conv_data_i,
  // output converters
  input wire logic [NUM_OUT-1:0] clear_i,
  output logic [NUM_OUT*12-1:0] out_latch_o,
  // remote sensors
  input wire logic remote_sensor_one_enable_i,
  input wire logic remote_sensor_two_enable_i,
  output logic signed [7:0] ideality_adjust_value_a_o,
  output logic signed [7:0] ideality_adjust_value_b_o,
  output logic default_ideality_a_o,
  output logic default_ideality_b_o,
  // configuration
  output mdg_pkg::mdg_word_t main_config_o,
  // open-drain pins
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);

  // combined reset: power-on/hardware pin or software request
  // both requests act on one edge, so neither can race the other
  logic rst;
  always_comb
    rst = !rst_n_i || sw_reset_i;

  // storage
  logic [7:0] ideal_a_reg;
  logic [7:0] ideal_b_reg;
  mdg_pkg::mdg_code_t res_reg [NUM_RES];
  mdg_pkg::mdg_code_t code_reg [NUM_OUT];
  mdg_pkg::mdg_code_t clr_reg [NUM_OUT];
  mdg_pkg::mdg_word_t cfg_reg;

  // address decode
  logic in_res;
  logic in_code;
  logic in_clr;
  logic [3:0] res_idx;
  logic [3:0] code_idx;
  logic [3:0] clr_idx;
  logic [6:0] res_off;
  logic [6:0] code_off;
  logic [6:0] clr_off;

  // windows of consecutive registers
  always_comb
  begin
    in_res = reg_addr_i >= `MDG_ADDR_RES_FIRST
      && reg_addr_i <= `MDG_ADDR_RES_LAST;
    in_code = reg_addr_i >= `MDG_ADDR_CODE_FIRST
      && reg_addr_i <= `MDG_ADDR_CODE_LAST;
    in_clr = reg_addr_i >= `MDG_ADDR_CLR_FIRST
      && reg_addr_i <= `MDG_ADDR_CLR_LAST;
    res_off = reg_addr_i - `MDG_ADDR_RES_FIRST;
    code_off = reg_addr_i - `MDG_ADDR_CODE_FIRST;
    clr_off = reg_addr_i - `MDG_ADDR_CLR_FIRST;
    res_idx = res_off[3:0];
    code_idx = code_off[3:0];
    clr_idx = clr_off[3:0];
  end

  // pins lent to enabled remote sensors
  // a sensor owns its pins, so host writes must not fight it
  logic [NUM_PINS-1:0] lent;
  always_comb
  begin
    lent = '0;
    if (remote_sensor_one_enable_i) // see [R16]
      lent = lent | `MDG_PIN_SENSOR_ONE; // see [R13]
    if (remote_sensor_two_enable_i) // see [R16]
      lent = lent | `MDG_PIN_SENSOR_TWO; // see [R14]
  end

  // incoming adjust byte; its place depends on the port
  // the leftover byte is dropped here and never stored
  logic [7:0] adj_wbyte;
  always_comb
  begin
    if (port_sel_i == mdg_pkg::MDG_PORT_I2C)
      adj_wbyte = reg_wdata_i[15:8]; // see [R3]
    else
      adj_wbyte = reg_wdata_i[7:0]; // see [R2]
  end

  // ideality adjust bytes; the other byte is never stored
  always_ff @(posedge clock_i)
  begin
    if (rst)
    begin
      ideal_a_reg <= `MDG_IDEAL_RST;
      ideal_b_reg <= `MDG_IDEAL_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `MDG_ADDR_IDEAL_A)
        ideal_a_reg <= adj_wbyte; // see [R1]
      if (reg_addr_i == `MDG_ADDR_IDEAL_B)
        ideal_b_reg <= adj_wbyte; // see [R1]
    end
  end

  // signed adjust toward the correction logic
  // one cycle behind the register; correction runs far slower
  always_ff @(posedge clock_i)
  begin
    if (rst)
    begin
      ideality_adjust_value_a_o <= '0;
      ideality_adjust_value_b_o <= '0;
      default_ideality_a_o <= 1'b1;
      default_ideality_b_o <= 1'b1;
    end
    else
    begin
      ideality_adjust_value_a_o <= signed'(ideal_a_reg); // see [R4]
      ideality_adjust_value_b_o <= signed'(ideal_b_reg); // see [R4]
      // zero selects the default ideality
      default_ideality_a_o <= ideal_a_reg == `MDG_IDEAL_RST; // see [R4]
      default_ideality_b_o <= ideal_b_reg == `MDG_IDEAL_RST; // see [R4]
    end
  end

  // result target and format
  // a differential result overwrites the single-ended slot
  logic [3:0] res_dst;
  mdg_pkg::mdg_code_t res_val;
  always_comb
  begin
    if (conv_diff_i)
    begin
      // pair 0/1 lands in 0, pair 2/3 in 2
      res_dst = {2'b00, conv_ch_i[1], 1'b0}; // see [R7]
      // offset-binary code to twos complement by msb flip
      res_val = conv_data_i ^ 12'h800; // see [R7]
    end
    else
    begin
      res_dst = conv_ch_i; // see [R6]
      res_val = conv_data_i; // see [R6]
    end
  end

  genvar r;
  generate
    for (r = 0; r < NUM_RES; r++)
    begin : g_res
      // only the converter writes; host writes never reach here
      always_ff @(posedge clock_i)
      begin
        if (rst)
          res_reg[r] <= `MDG_RES_RST;
        else if (conv_wr_i && res_dst == 4'(r))
          res_reg[r] <= res_val; // see [R5] [R17]
      end
    end
  endgenerate

  // output codes, clear codes and converter latches
  genvar d;
  generate
    for (d = 0; d < NUM_OUT; d++)
    begin : g_out
      logic hit_code;
      logic hit_clr;
      // per-converter write strobes from the shared decode
      always_comb
      begin
        hit_code = reg_wr_i && in_code && code_idx == 4'(d);
        hit_clr = reg_wr_i && in_clr && clr_idx == 4'(d);
      end

      // host-written output code
      always_ff @(posedge clock_i)
      begin
        if (rst)
          code_reg[d] <= `MDG_CODE_RST;
        else if (hit_code)
          code_reg[d] <= reg_wdata_i[`MDG_CODE_MSB:0]; // see [R8]
      end

      // host-written clear code
      always_ff @(posedge clock_i)
      begin
        if (rst)
          clr_reg[d] <= `MDG_CODE_RST;
        else if (hit_clr)
          clr_reg[d] <= reg_wdata_i[`MDG_CODE_MSB:0]; // see [R9]
      end

      // clear wins over a code write so a shutdown is never missed
      // limitation: no synchronous-load mode, latch tracks its code
      always_ff @(posedge clock_i)
      begin
        if (rst)
          out_latch_o[d*12 +: 12] <= `MDG_CODE_RST;
        else if (clear_i[d])
          out_latch_o[d*12 +: 12] <= clr_reg[d]; // see [R9]
        else
          out_latch_o[d*12 +: 12] <= code_reg[d]; // see [R8]
      end
    end
  endgenerate

  // main configuration; reserved bits keep zero
  // masking on the way in keeps reserved reads at zero
  always_ff @(posedge clock_i)
  begin
    if (rst)
      cfg_reg <= `MDG_CFG_RST; // see [R15]
    else if (reg_wr_i && reg_addr_i == `MDG_ADDR_CFG)
      cfg_reg <= reg_wdata_i & `MDG_CFG_WMASK; // see [R15]
  end

  // configuration mirrored out from its own flop
  // costs a cycle of lag but keeps the port a plain flop
  always_ff @(posedge clock_i)
  begin
    if (rst)
      main_config_o <= `MDG_CFG_RST;
    else
      main_config_o <= cfg_reg;
  end

  // general-purpose pins
  logic pin_wr;
  logic [NUM_PINS-1:0] pin_level;
  always_comb
    pin_wr = reg_wr_i && reg_addr_i == `MDG_ADDR_PIN;

  mdg_pin_port #(
    .NUM_PINS(NUM_PINS)
  ) u_pins (
    .clock_i(clock_i),
    .rst_i(rst),
    .wr_i(pin_wr),
    .wdata_i(reg_wdata_i[NUM_PINS-1:0]),
    .ignore_i(lent),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_o(pin_oe_o),
    .level_o(pin_level)
  );

  // ideality layout as read back
  // follows the port selected now, not the one at write time
  function automatic mdg_pkg::mdg_word_t adj_word(
    input logic [7:0] adj,
    input mdg_pkg::mdg_port_t sel
  );
    if (sel == mdg_pkg::MDG_PORT_I2C)
      adj_word = {adj, `MDG_IDEAL_FILL}; // see [R3]
    else
      adj_word = {`MDG_ZERO_BYTE, adj}; // see [R2]
  endfunction

  // read mux; unmapped addresses read zero
  mdg_pkg::mdg_word_t rd_word;
  always_comb
  begin
    rd_word = '0;
    if (reg_addr_i == `MDG_ADDR_IDEAL_A)
      rd_word = adj_word(ideal_a_reg, port_sel_i);
    else if (reg_addr_i == `MDG_ADDR_IDEAL_B)
      rd_word = adj_word(ideal_b_reg, port_sel_i);
    else if (in_res)
      rd_word = {`MDG_ZERO_NIBBLE, res_reg[res_idx]}; // see [R5]
    else if (in_code)
      rd_word = {`MDG_ZERO_NIBBLE, code_reg[code_idx]}; // see [R8]
    else if (in_clr)
      rd_word = {`MDG_ZERO_NIBBLE, clr_reg[clr_idx]}; // see [R9]
    else if (reg_addr_i == `MDG_ADDR_PIN)
      rd_word = {`MDG_ZERO_BYTE, pin_level}; // see [R11]
    else if (reg_addr_i == `MDG_ADDR_CFG)
      rd_word = cfg_reg; // see [R15]
  end

  // read answer one cycle after the strobe, held until next read
  // holding the word lets a slow port shift it out at leisure
  always_ff @(posedge clock_i)
  begin
    if (rst)
      rd_data_o <= '0;
    else if (reg_rd_i)
      rd_data_o <= rd_word;
  end

  // one-cycle valid marks the answer
  // never held, so a stale answer cannot be taken twice
  always_ff @(posedge clock_i)
  begin
    if (rst)
      rd_valid_o <= 1'b0;
    else
      rd_valid_o <= reg_rd_i;
  end

endmodule

/* bench/mdg_regs_chk.sv */
// Purpose: port checker for the register slice
// Assumes: one clock, synchronous active-low and software resets
// Notes: bound to the top from the bench file
`timescale 1ns/1ps
module mdg_regs_chk #(
  parameter int NUM_OUT = 12,
  parameter int NUM_PINS = 8
) (
  // clock and resets
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  // register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire mdg_pkg::mdg_word_t reg_wdata_i,
  input wire logic rd_valid_o,
  // converters, sensors, pins
  input wire logic [NUM_OUT-1:0] clear_i,
  input wire logic [NUM_OUT*12-1:0] out_latch_o,
  input wire logic remote_sensor_one_enable_i,
  input wire logic remote_sensor_two_enable_i,
  input wire logic signed [7:0] ideality_adjust_value_a_o,
  input wire logic default_ideality_a_o,
  input wire mdg_pkg::mdg_word_t main_config_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o
);
  // every check but the reset one is muted while a reset is applied
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i || sw_reset_i);

  a_read_answer: assert property (
    reg_rd_i |=> rd_valid_o) else $error("read strobe without answer");
  a_pin_write_drive: assert property (
    reg_wr_i && reg_addr_i == 7'h4B
    |=> ##1 pin_oe_o[3:0] == ~$past(reg_wdata_i[3:0], 2))
    else $error("pin drive does not follow written bits");
  a_lent_pins_one: assert property (
    remote_sensor_one_enable_i |=> pin_oe_o[5:4] == 2'h0)
    else $error("pins 4 and 5 driven while sensor one on");
  a_lent_pins_two: assert property (
    remote_sensor_two_enable_i |=> pin_oe_o[7:6] == 2'h0)
    else $error("pins 6 and 7 driven while sensor two on");
  a_clear_hold: assert property (
    (clear_i[0] && !reg_wr_i) [*2] |=> $stable(out_latch_o[11:0]))
    else $error("latch moved while held clear");
  a_code_follow: assert property (
    (reg_wr_i && reg_addr_i == 7'h33) ##1 !clear_i[0]
    |=> out_latch_o[11:0] == $past(reg_wdata_i[11:0], 2))
    else $error("latch does not follow code write");
  a_reset_values: assert property (
    disable iff (1'b0) (!rst_n_i || sw_reset_i)
    |=> pin_oe_o == '0 && main_config_o == 16'h2000)
    else $error("bad values after reset");
  a_ideal_default: assert property (
    default_ideality_a_o == (ideality_adjust_value_a_o == 8'sh00))
    else $error("default ideality flag disagrees with adjust");
endmodule

/* bench/mdg_pin_pad.sv */
// Purpose: open-drain pin pads with pull-ups
// Assumes: enable high sinks the line low
// Notes: ext_low_i lets the bench sink a pin from outside
`timescale 1ns/1ps
module mdg_pin_pad (
  // sinks on the line
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] ext_low_i,
  // resolved level
  output logic [7:0] level_o
);
  // pull-up wins unless someone sinks the line
  assign level_o = ~(pin_oe_i | ext_low_i);
endmodule

/* bench/mdg_regs_tb_top.sv */
// Purpose: self-checking bench for the register slice
// Assumes: strobes one cycle, reads answer one cycle later
// Notes: table rows first, then hand-written cases
`timescale 1ns/1ps
module mdg_regs_tb_top;
  typedef struct packed {
    logic w;
    logic [6:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } mdg_row_t;
  mdg_row_t rows [15];
  logic clock_i, rst_n_i, sw_reset_i, reg_wr_i, reg_rd_i, rd_valid_o;
  logic conv_wr_i, conv_diff_i, dflt_a, dflt_b, s1, s2;
  logic [6:0] reg_addr_i;
  logic [3:0] conv_ch_i;
  logic [11:0] conv_data_i, clear_i;
  logic [143:0] out_latch_o;
  logic [7:0] pin_i, pin_o, pin_oe_o, ext_low, adj_a, adj_b;
  mdg_pkg::mdg_port_t port_sel_i;
  mdg_pkg::mdg_word_t reg_wdata_i, rd_data_o, cfg;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  mdg_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .sw_reset_i(sw_reset_i), .port_sel_i(port_sel_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .conv_wr_i(conv_wr_i),
    .conv_diff_i(conv_diff_i), .conv_ch_i(conv_ch_i),
    .conv_data_i(conv_data_i), .clear_i(clear_i),
    .out_latch_o(out_latch_o), .remote_sensor_one_enable_i(s1),
    .remote_sensor_two_enable_i(s2), .ideality_adjust_value_a_o(adj_a),
    .ideality_adjust_value_b_o(adj_b), .default_ideality_a_o(dflt_a),
    .default_ideality_b_o(dflt_b), .main_config_o(cfg), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  mdg_pin_pad pad (.pin_oe_i(pin_oe_o), .ext_low_i(ext_low),
    .level_o(pin_i));

  // clock, 4 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // hang guard, far above the some 125 cycles needed
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input string n, input mdg_pkg::mdg_word_t e,
                     input mdg_pkg::mdg_word_t g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // two idle cycles let pin drive settle before the next access
  task automatic wr(input logic [6:0] a, input mdg_pkg::mdg_word_t d);
    tick(1);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
    tick(2);
  endtask

  task automatic rd(input logic [6:0] a, input mdg_pkg::mdg_word_t e);
    tick(1);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'b0;
    chk("rd_valid_o", 16'h0001, {15'h0000, rd_valid_o});
    chk("rd_data_o", e, rd_data_o);
  endtask

  task automatic cv(input logic df, input logic [3:0] ch,
                    input mdg_pkg::mdg_code_t d);
    tick(1);
    conv_wr_i = 1'b1;
    conv_diff_i = df;
    conv_ch_i = ch;
    conv_data_i = d;
    tick(1);
    conv_wr_i = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // reset values, then writes with read-back, in the serial-peripheral mode
  initial
  begin
    rows = '{'{1'b0, 7'h21, 16'h0, 16'h0000}, '{1'b0, 7'h4B, 16'h0, 16'h00FF},
      '{1'b0, 7'h4C, 16'h0, 16'h2000}, '{1'b0, 7'h3F, 16'h0, 16'h0000},
      '{1'b0, 7'h33, 16'h0, 16'h0000}, '{1'b1, 7'h21, 16'h1234, 16'h0034},
      '{1'b1, 7'h22, 16'hFF80, 16'h0080}, '{1'b1, 7'h33, 16'hFABC, 16'h0ABC},
      '{1'b1, 7'h3E, 16'h0FFF, 16'h0FFF}, '{1'b1, 7'h3F, 16'h1555, 16'h0555},
      '{1'b1, 7'h4A, 16'h8123, 16'h0123}, '{1'b1, 7'h4C, 16'hFFFF, 16'h3EFF},
      '{1'b1, 7'h23, 16'h0FFF, 16'h0000}, '{1'b1, 7'h10, 16'hFFFF, 16'h0000},
      '{1'b1, 7'h4B, 16'h00F0, 16'h00F0}};
    {rst_n_i, sw_reset_i, reg_wr_i, reg_rd_i, conv_wr_i, conv_diff_i} = '0;
    {s1, s2, reg_addr_i, conv_ch_i, conv_data_i, clear_i} = '0;
    reg_wdata_i = '0;
    ext_low = '0;
    port_sel_i = mdg_pkg::MDG_PORT_SPI;
    tick(5);
    rst_n_i = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // outputs that mirror registers written by the rows
    chk("main_config_o", 16'h3EFF, cfg);
    chk("adj_b", 16'h0080, {8'h00, adj_b});
    chk("dflt_b", 16'h0000, {15'h0000, dflt_b});
    chk("pin_o", 16'h0000, {8'h00, pin_o});
    // results: single-ended direct, differential with msb flipped
    cv(1'b0, 4'hF, 12'hABC);
    rd(7'h32, 16'h0ABC);
    cv(1'b1, 4'h0, 12'h7FF);
    rd(7'h23, 16'h0FFF);
    cv(1'b1, 4'h2, 12'h0FF);
    rd(7'h25, 16'h08FF);
    // clear code wins while held, code returns after
    clear_i[0] = 1'b1;
    tick(2);
    chk("latch0", 16'h0555, {4'h0, out_latch_o[11:0]});
    clear_i[0] = 1'b0;
    tick(2);
    chk("latch0", 16'h0ABC, {4'h0, out_latch_o[11:0]});
    chk("latch11", 16'h0FFF, {4'h0, out_latch_o[143:132]});
    // two-wire layout of the ideality registers
    port_sel_i = mdg_pkg::MDG_PORT_I2C;
    rd(7'h22, 16'h80FF);
    wr(7'h21, 16'h0012);
    rd(7'h21, 16'h00FF);
    chk("dflt_a", 16'h0001, {15'h0000, dflt_a});
    wr(7'h21, 16'h80FF);
    rd(7'h21, 16'h80FF);
    chk("adj_a", 16'h0080, {8'h00, adj_a});
    // pin 7 sunk from outside shows in the read
    ext_low = 8'h80;
    rd(7'h4B, 16'h0070);
    ext_low = 8'h00;
    s1 = 1'b1;
    s2 = 1'b1;
    wr(7'h4B, 16'h0000);
    chk("pin_oe_o", 16'h000F, {8'h00, pin_oe_o});
    rd(7'h4B, 16'h0000);
    s1 = 1'b0;
    s2 = 1'b0;
    // lent bits kept their ones, so pins 7..4 stay released
    rd(7'h4B, 16'h00F0);
    tick(1);
    sw_reset_i = 1'b1;
    tick(1);
    sw_reset_i = 1'b0;
    rd(7'h4B, 16'h00FF);
    rd(7'h33, 16'h0000);
    rd(7'h21, 16'h00FF);
    rd(7'h4C, 16'h2000);
    chk("main_config_o", 16'h2000, cfg);
    final_report();
  end
endmodule

bind mdg_regs mdg_regs_chk #(.NUM_OUT(NUM_OUT), .NUM_PINS(NUM_PINS)) chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .sw_reset_i(sw_reset_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .rd_valid_o(rd_valid_o), .clear_i(clear_i),
  .out_latch_o(out_latch_o),
  .remote_sensor_one_enable_i(remote_sensor_one_enable_i),
  .remote_sensor_two_enable_i(remote_sensor_two_enable_i),
  .ideality_adjust_value_a_o(ideality_adjust_value_a_o),
  .default_ideality_a_o(default_ideality_a_o),
  .main_config_o(main_config_o), .pin_oe_o(pin_oe_o));
